// [core/fuel_gauge_tuning_control.v]
// Fuel gauge tuning registers and the gauge decisions they steer
//
// Summary of operation
// R1: Voltage percentage moves only after more than N same-direction changes, N=4,8,1,2 by code.
// R2: Counter percentage is debounced alike with its own two-bit field.
// R3: Calibration starts when voltage percentage is below warning level plus 3, or plus 6.
// R4: First end condition is voltage percentage at least 95, or exactly 100 when set.
// R5: Second end bit chooses waiting for charge finished or not.
// R6: After charging status clears, wait 68 ms or 120 ms for the finished indication.
// R7: While charging, indicated percentage may drop unless the no-decrease bit is set.
// R8: While charging, drops pass only beyond a hysteresis of 4..7 or 0..3 percent.
// R9: Resistance calculation needs current of at least 300 mA, or 150 mA when set.
// R10: Resistance calibration fires when voltage percentage delta exceeds N percent.
// R11: Both registers are read-write and reset to zero.
// R12: Shutdown warning level is a 4-bit 0..15 percent input.
// R13: A direction reversal restarts a debounce run from the start.
`timescale 1ns/1ps
`include "gauge_tuning_defines.vh"
module fuel_gauge_tuning_control #(
   parameter WAIT_SHORT_CYC = `WAIT_SHORT_MS * `CYC_PER_MS,
   parameter WAIT_LONG_CYC = `WAIT_LONG_MS * `CYC_PER_MS
) (
   input wire clk_sys,
   input wire rst,
   input wire [`ADDR_W-1:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   input wire charging_status_bit,
   input wire charge_done,
   input wire [3:0] shutdown_warning_level,
   input wire sample_valid,
   input wire [6:0] ocv_pct_raw,
   input wire [6:0] cc_pct_raw,
   input wire [6:0] indicated_pct_raw,
   input wire [11:0] battery_current_ma,
   input wire [6:0] voltage_percentage_delta,
   output wire [6:0] ocv_pct,
   output wire [6:0] cc_pct,
   output reg [6:0] indicated_pct,
   output reg cal_start,
   output reg cal_end,
   output reg battery_internal_resistance_calc_en,
   output reg battery_internal_resistance_cal_trig
);
   // --------------------------------------------------------------
   // Input synchronisers
   // --------------------------------------------------------------
   reg chg_s1_reg;
   reg chg_s2_reg;
   reg done_s1_reg;
   reg done_s2_reg;
   reg chg_d_reg;
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         chg_s1_reg <= 1'b0;
         chg_s2_reg <= 1'b0;
         done_s1_reg <= 1'b0;
         done_s2_reg <= 1'b0;
         chg_d_reg <= 1'b0;
      end else begin
         chg_s1_reg <= charging_status_bit;
         chg_s2_reg <= chg_s1_reg;
         done_s1_reg <= charge_done;
         done_s2_reg <= done_s1_reg;
         chg_d_reg <= chg_s2_reg;
      end
   end
   // --------------------------------------------------------------
   // Register file
   // --------------------------------------------------------------
   reg [7:0] deb_cal_reg;
   reg [7:0] hyst_res_reg;
   reg rd_pend_reg;
   wire [`ADDR_W-3:0] idx;
   wire hit_a;
   wire hit_b;
   assign idx = avs_address[`ADDR_W-1:2];
   assign hit_a = (idx == `IDX_DEBOUNCE_CAL_END);
   assign hit_b = (idx == `IDX_HYST_RESIST);
   // Reads take one wait cycle; writes complete at once
   assign avs_waitrequest = avs_read & ~rd_pend_reg;
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         // R11: zero on reset
         deb_cal_reg <= `REG_RESET;
         hyst_res_reg <= `REG_RESET;
         rd_pend_reg <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         rd_pend_reg <= avs_read & ~rd_pend_reg;
         // R11: software write
         if (avs_write && avs_byteenable[0]) begin
            if (hit_a) begin
               deb_cal_reg <= avs_writedata[7:0];
            end
            if (hit_b) begin
               hyst_res_reg <= avs_writedata[7:0];
            end
         end
         // R11: software read
         if (avs_read && !rd_pend_reg) begin
            if (hit_a) begin
               avs_readdata <= {24'h00_0000, deb_cal_reg};
            end else if (hit_b) begin
               avs_readdata <= {24'h00_0000, hyst_res_reg};
            end else begin
               avs_readdata <= 32'h0000_0000;
            end
         end
      end
   end
   // --------------------------------------------------------------
   // Percentage debounce
   // --------------------------------------------------------------
   // R1: voltage percentage debounce
   pct_debounce #(.PW(7)) u_ocv_deb (
      .clk_sys(clk_sys),
      .rst(rst),
      .sel(deb_cal_reg[`F_OCV_DEB_HI:`F_OCV_DEB_LO]),
      .sample_valid(sample_valid),
      .sample(ocv_pct_raw),
      .pct_reg(ocv_pct)
   );
   // R2: counter percentage debounce
   pct_debounce #(.PW(7)) u_cc_deb (
      .clk_sys(clk_sys),
      .rst(rst),
      .sel(deb_cal_reg[`F_CC_DEB_HI:`F_CC_DEB_LO]),
      .sample_valid(sample_valid),
      .sample(cc_pct_raw),
      .pct_reg(cc_pct)
   );
   // --------------------------------------------------------------
   // Calibration start and end
   // --------------------------------------------------------------
   wire [6:0] start_thr;
   wire end_pct_ok;
   reg [31:0] wait_cnt_reg;
   reg waiting_reg;
   reg wait_over_reg;
   // R12: warning level in percent
   // R3: start threshold
   assign start_thr = {3'b000, shutdown_warning_level} +
      (deb_cal_reg[`F_CAL_START] ? `START_OFFS_HIGH : `START_OFFS_LOW);
   // R4: first end condition
   assign end_pct_ok = deb_cal_reg[`F_CAL_END0] ? (ocv_pct == `END_PCT_FULL) :
      (ocv_pct >= `END_PCT_LOW);
   // R6: wait window after charging status clears
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wait_cnt_reg <= 32'h0000_0000;
         waiting_reg <= 1'b0;
         wait_over_reg <= 1'b0;
      end else if (chg_s2_reg) begin
         waiting_reg <= 1'b0;
         wait_over_reg <= 1'b0;
      end else if (chg_d_reg) begin
         waiting_reg <= 1'b1;
         wait_cnt_reg <= deb_cal_reg[`F_CAL_END2] ? WAIT_LONG_CYC[31:0] :
            WAIT_SHORT_CYC[31:0];
      end else if (waiting_reg) begin
         if (done_s2_reg) begin
            waiting_reg <= 1'b0;
            wait_over_reg <= 1'b1;
         end else if (wait_cnt_reg <= 32'h0000_0001) begin
            // Window closed with no finished indication: calibration may not end
            waiting_reg <= 1'b0;
         end else begin
            wait_cnt_reg <= wait_cnt_reg - 32'h0000_0001;
         end
      end
   end
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cal_start <= 1'b0;
         cal_end <= 1'b0;
      end else begin
         // R3: start compare
         cal_start <= (ocv_pct < start_thr);
         // R5: wait or not for charge finished
         if (deb_cal_reg[`F_CAL_END1]) begin
            cal_end <= end_pct_ok;
         end else begin
            cal_end <= end_pct_ok & wait_over_reg & done_s2_reg;
         end
      end
   end
   // --------------------------------------------------------------
   // Indicated percentage while charging
   // --------------------------------------------------------------
   reg [6:0] hyst;
   reg [6:0] res_thr;
   always @* begin
      // R8: hysteresis code map
      hyst = {4'h0, ~hyst_res_reg[`F_HYST_HI], hyst_res_reg[`F_HYST_HI-1:`F_HYST_LO]};
      // R10: threshold code map
      res_thr = {4'h0, ~hyst_res_reg[`F_RES_THR_HI], hyst_res_reg[`F_RES_THR_HI-1:`F_RES_THR_LO]};
   end
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         indicated_pct <= 7'h00;
      end else if (sample_valid) begin
         if (!chg_s2_reg || indicated_pct_raw >= indicated_pct) begin
            indicated_pct <= indicated_pct_raw;
         end else if (hyst_res_reg[`F_NO_DECREASE]) begin
            // R7: decrease blocked
            indicated_pct <= indicated_pct;
         end else if (indicated_pct - indicated_pct_raw > hyst) begin
            // R8: decrease beyond hysteresis
            indicated_pct <= indicated_pct_raw;
         end
      end
   end
   // --------------------------------------------------------------
   // Internal resistance conditions
   // --------------------------------------------------------------
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         battery_internal_resistance_calc_en <= 1'b0;
         battery_internal_resistance_cal_trig <= 1'b0;
      end else begin
         // R9: current condition
         battery_internal_resistance_calc_en <= battery_current_ma >=
            (hyst_res_reg[`F_RES_CURR] ? `CURR_MIN_LOW_MA : `CURR_MIN_HIGH_MA);
         // R10: delta trigger
         battery_internal_resistance_cal_trig <= (voltage_percentage_delta > res_thr);
      end
   end
endmodule // fuel_gauge_tuning_control

// [core/gauge_tuning_defines.vh]
// Constants for the fuel gauge tuning control block
`ifndef GAUGE_TUNING_DEFINES_VH
`define GAUGE_TUNING_DEFINES_VH
// ---------------------------------------------------------------
// Register map (printed offsets are indices, byte address = 4 x index)
// ---------------------------------------------------------------
`define IDX_DEBOUNCE_CAL_END 8'hea
`define IDX_HYST_RESIST 8'heb
`define ADDR_W 10
`define REG_RESET 8'h00
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define F_OCV_DEB_HI 7
`define F_OCV_DEB_LO 6
`define F_CC_DEB_HI 5
`define F_CC_DEB_LO 4
`define F_CAL_START 3
`define F_CAL_END0 2
`define F_CAL_END1 1
`define F_CAL_END2 0
`define F_NO_DECREASE 7
`define F_HYST_HI 6
`define F_HYST_LO 4
`define F_RES_CURR 3
`define F_RES_THR_HI 2
`define F_RES_THR_LO 0
// ---------------------------------------------------------------
// Thresholds
// ---------------------------------------------------------------
`define START_OFFS_LOW 7'h03
`define START_OFFS_HIGH 7'h06
`define END_PCT_LOW 7'h5f
`define END_PCT_FULL 7'h64
`define CURR_MIN_LOW_MA 12'h096
`define CURR_MIN_HIGH_MA 12'h12c
`define WAIT_SHORT_MS 68
`define WAIT_LONG_MS 120
`define CLK_HZ 200000000
`define CYC_PER_MS (`CLK_HZ / 1000)
`endif

// [core/pct_debounce.v]
// Same-direction debounce of one capacity percentage
`timescale 1ns/1ps
module pct_debounce #(
   parameter PW = 7
) (
   input wire clk_sys,
   input wire rst,
   input wire [1:0] sel,
   input wire sample_valid,
   input wire [PW-1:0] sample,
   output reg [PW-1:0] pct_reg
);
   reg [3:0] run_reg;
   reg dir_up_reg;
   reg [3:0] need;
   wire differs;
   wire up;
   assign differs = (sample != pct_reg);
   assign up = (sample > pct_reg);
   // --------------------------------------------------------------
   // Run length required before update
   // --------------------------------------------------------------
   always @* begin
      case (sel)
         2'b00: need = 4'h4;
         2'b01: need = 4'h8;
         2'b10: need = 4'h1;
         default: need = 4'h2;
      endcase
   end
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pct_reg <= {PW{1'b0}};
         run_reg <= 4'h0;
         dir_up_reg <= 1'b0;
      end else if (sample_valid) begin
         if (!differs) begin
            run_reg <= 4'h0;
         end else if (run_reg != 4'h0 && up != dir_up_reg) begin
            // R13: reversal restarts run
            run_reg <= 4'h1;
            dir_up_reg <= up;
         end else if (run_reg >= need) begin
            // R1: update after more than N
            pct_reg <= sample;
            run_reg <= 4'h0;
         end else begin
            run_reg <= run_reg + 4'h1;
            dir_up_reg <= up;
         end
      end
   end
endmodule // pct_debounce

// [test/fuel_gauge_tuning_control_asserts.sv]
// Port checker for the fuel gauge tuning control block
`timescale 1ns/1ps
module fuel_gauge_tuning_control_asserts (
   input wire clk_sys,
   input wire rst,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest,
   input wire sample_valid,
   input wire [6:0] ocv_pct_raw,
   input wire [6:0] cc_pct_raw,
   input wire [11:0] battery_current_ma,
   input wire [6:0] voltage_percentage_delta,
   input wire [6:0] ocv_pct,
   input wire [6:0] cc_pct,
   input wire battery_internal_resistance_calc_en,
   input wire battery_internal_resistance_cal_trig
);
   // -----------------
   // Port properties
   // -----------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_write_no_wait: assert property (
      avs_write |-> !avs_waitrequest) else $error("write stalled");
   a_read_one_wait: assert property (
      $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("read wait wrong");
   a_read_upper_zero: assert property (
      avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000) else $error("upper bits");
   a_ocv_on_sample: assert property (
      $changed(ocv_pct) |-> $past(sample_valid) && ocv_pct == $past(ocv_pct_raw))
      else $error("ocv moved off sample");
   a_cc_on_sample: assert property (
      $changed(cc_pct) |-> $past(sample_valid) && cc_pct == $past(cc_pct_raw))
      else $error("cc moved off sample");
   a_calc_high: assert property (
      battery_current_ma >= 12'h12c [*3] |-> battery_internal_resistance_calc_en)
      else $error("calc not enabled");
   a_calc_low: assert property (
      battery_current_ma < 12'h096 [*3] |-> !battery_internal_resistance_calc_en)
      else $error("calc enabled low current");
   a_trig_high: assert property (
      voltage_percentage_delta > 7'h07 [*3] |-> battery_internal_resistance_cal_trig)
      else $error("trigger missing");
   a_trig_low: assert property (
      voltage_percentage_delta == 7'h00 [*3] |-> !battery_internal_resistance_cal_trig)
      else $error("trigger at zero delta");
endmodule // fuel_gauge_tuning_control_asserts
bind fuel_gauge_tuning_control fuel_gauge_tuning_control_asserts chk (
   .clk_sys(clk_sys), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .sample_valid(sample_valid), .ocv_pct_raw(ocv_pct_raw), .cc_pct_raw(cc_pct_raw),
   .battery_current_ma(battery_current_ma), .voltage_percentage_delta(voltage_percentage_delta),
   .ocv_pct(ocv_pct), .cc_pct(cc_pct),
   .battery_internal_resistance_calc_en(battery_internal_resistance_calc_en),
   .battery_internal_resistance_cal_trig(battery_internal_resistance_cal_trig)
);

// [test/fuel_gauge_tuning_control_test.sv]
// Self-checking bench for the fuel gauge tuning control block
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module fuel_gauge_tuning_control_test;
   // -----------------
   // Signals and dut
   // -----------------
   reg clk_sys = 0, rst = 1, avs_read = 0, avs_write = 0, chg = 0, done = 0, sv = 0;
   reg [9:0] addr = 0;
   reg [31:0] wdata = 0, seed = 32'h0000_9546, q;
   reg [3:0] be = 4'hf, lvl = 0;
   reg [6:0] ocv_raw = 0, cc_raw = 0, ind_raw = 0, dlt = 0;
   reg [11:0] cur = 0;
   wire [31:0] rdata;
   wire wait_req, start, fin, cen, trig;
   wire [6:0] ocv, cc, ind;
   int errors = 0, n_compared = 0, cyc = 0, i, j, n, run[2], dir[2], mo[2], upd[2], nn[2];
   int regm[2];
   fuel_gauge_tuning_control #(.WAIT_SHORT_CYC(50), .WAIT_LONG_CYC(80)) dut (
      .clk_sys(clk_sys), .rst(rst), .avs_address(addr), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(wdata), .avs_byteenable(be),
      .avs_readdata(rdata), .avs_waitrequest(wait_req), .charging_status_bit(chg),
      .charge_done(done), .shutdown_warning_level(lvl), .sample_valid(sv),
      .ocv_pct_raw(ocv_raw), .cc_pct_raw(cc_raw), .indicated_pct_raw(ind_raw),
      .battery_current_ma(cur), .voltage_percentage_delta(dlt), .ocv_pct(ocv),
      .cc_pct(cc), .indicated_pct(ind), .cal_start(start), .cal_end(fin),
      .battery_internal_resistance_calc_en(cen), .battery_internal_resistance_cal_trig(trig));
   initial forever #2.5 clk_sys = ~clk_sys;
   // -----------------
   // Tasks and model
   // -----------------
   function int rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed & 32'h7fff_ffff;
   endfunction
   function int nmap(input int c);
      return c == 0 ? 4 : c == 1 ? 8 : c == 2 ? 1 : 2;
   endfunction
   function int pick(input int k);
      int r;
      r = rnd();
      pick = r % 8 == 0 || upd[k] ? mo[k] : r % 8 == 7 ? mo[k] - 1 : mo[k] + 1 + r / 8 % 4;
      upd[k] = 0;
      if (pick < 0 || pick > 100) pick = 50;
   endfunction
   task deb(input int k, input int s);
      if (s == mo[k]) run[k] = 0;
      else if (run[k] == 0 || (s > mo[k]) != dir[k]) begin
         run[k] = 1;
         dir[k] = s > mo[k];
      end else if (run[k] < nn[k]) run[k]++;
      else begin
         mo[k] = s;
         run[k] = 0;
         upd[k] = 1;
      end
   endtask
   task wr(input int idx, input int d, input [3:0] b);
      @(posedge clk_sys);
      addr <= 10'(idx * 4);
      wdata <= 32'(d & 255);
      be <= b;
      avs_write <= 1;
      @(posedge clk_sys);
      while (wait_req) @(posedge clk_sys);
      avs_write <= 0;
   endtask
   task rd(input int idx);
      @(posedge clk_sys);
      addr <= 10'(idx * 4);
      avs_read <= 1;
      @(posedge clk_sys);
      while (wait_req) @(posedge clk_sys);
      q = rdata;
      avs_read <= 0;
   endtask
   task step(input int o, input int c, input int d);
      @(posedge clk_sys);
      ocv_raw <= 7'(o);
      cc_raw <= 7'(c);
      ind_raw <= 7'(d);
      sv <= 1;
      @(posedge clk_sys);
      sv <= 0;
      deb(0, o);
      deb(1, c);
      @(posedge clk_sys);
      `CHK(ocv, 7'(mo[0]))
      `CHK(cc, 7'(mo[1]))
   endtask
   task close_out;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc > 30000) begin
         errors++;
         close_out;
      end
   end
   // -----------------
   // Scenarios
   // -----------------
   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 0;
      for (i = 0; i < 6; i++) begin
         j = rnd() % 256;
         rd(8'hea + i % 2);
         `CHK(q, 32'(regm[i % 2]))
         wr(8'hea + i % 2, j, 4'h1);
         regm[i % 2] = j;
         wr(8'hea + i % 2, ~j, 4'he);
         wr(8'hec, 8'hff, 4'hf);
         rd(8'hea + i % 2);
         `CHK(q, 32'(j))
         rd(8'he9);
         `CHK(q, 32'h0000_0000)
      end
      $display("registers done");
      for (i = 0; i < 240; i++) begin
         if (i % 60 == 0) begin
            n = i / 60;
            nn[0] = nmap(n);
            nn[1] = nmap(3 - n);
            step(mo[0], mo[1], 0);
            wr(8'hea, n * 64 + (3 - n) * 16, 4'h1);
         end
         step(pick(0), pick(1), rnd() % 101);
         `CHK(ind, ind_raw)
      end
      $display("debounce done");
      for (i = 0; i < 16; i++) begin
         n = i % 8 < 4 ? i % 8 + 4 : i % 8 - 4;
         wr(8'heb, i * 16, 4'h1);
         chg <= 0;
         repeat (3) @(posedge clk_sys);
         step(mo[0], mo[1], 50);
         chg <= 1;
         repeat (3) @(posedge clk_sys);
         step(mo[0], mo[1], 50 - n);
         `CHK(ind, 7'h32)
         step(mo[0], mo[1], 49 - n);
         `CHK(ind, i > 7 ? 7'h32 : 7'(49 - n))
         step(mo[0], mo[1], 60);
         `CHK(ind, 7'h3c)
      end
      chg <= 0;
      $display("indication done");
      n = rnd() % 16;
      lvl <= 4'(n);
      nn[0] = 1;
      nn[1] = 1;
      for (i = 0; i < 14; i++) begin
         j = i < 8 ? n + (i % 4 < 2 ? i % 4 + 2 : i % 4 + 3) : i % 3 ? 95 + (i % 3 - 1) * 5 : 94;
         wr(8'hea, i < 8 ? 8'ha2 + (i / 4) * 8 : 8'ha2 + (i / 11) * 4, 4'h1);
         repeat (3) step(j, mo[1], 0);
         repeat (3) @(posedge clk_sys);
         if (i < 8)
            `CHK(start, j < n + 3 || (i > 3 && j < n + 6))
         else
            `CHK(fin, j == 100 || (j == 95 && i < 11))
      end
      wr(8'hea, 8'ha0, 4'h1);
      chg <= 1;
      repeat (8) @(posedge clk_sys);
      chg <= 0;
      repeat (20) @(posedge clk_sys);
      `CHK(fin, 1'b0)
      done <= 1;
      repeat (6) @(posedge clk_sys);
      `CHK(fin, 1'b1)
      // Finished indication late for the short window, in time for the long one
      for (i = 0; i < 2; i++) begin
         done <= 0;
         wr(8'hea, 8'ha1 - i, 4'h1);
         chg <= 1;
         repeat (8) @(posedge clk_sys);
         chg <= 0;
         repeat (60) @(posedge clk_sys);
         done <= 1;
         repeat (6) @(posedge clk_sys);
         `CHK(fin, i == 0)
      end
      $display("calibration done");
      for (i = 0; i < 32; i++) begin
         n = i / 2 % 8 < 4 ? i / 2 % 8 + 4 : i / 2 % 8 - 4;
         if (i % 2 == 0) wr(8'heb, i / 2, 4'h1);
         cur <= 12'(150 + (i % 2) * 150);
         dlt <= 7'(n + i % 2);
         repeat (4) @(posedge clk_sys);
         `CHK(cen, i % 2 == 1 || i > 15)
         `CHK(trig, i % 2 == 1)
      end
      $display("resistance done");
      close_out;
   end
endmodule // fuel_gauge_tuning_control_test
